// *** fhc_host.sv ***
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "fhc_regs.svh"
// Notes on behaviour
// - operations start only by command sequences
// - poll status register for completion and outcome; no poll follows suspend or any operation after it until resume or power-down
// - wait recovery time before trusting reads
// - wait wake time before command writes
module fhc_host #(
  parameter int ADDR_W = 21
) (
  // clock and reset
  input  wire  logic                  clk,
  input  wire  logic                  rst_b,
  // local register port
  input  wire  logic [3:0]            reg_addr,
  input  wire  logic [31:0]           reg_wdata,
  input  wire  logic                  reg_wr,
  input  wire  logic                  reg_rd,
  output logic       [31:0]           reg_rdata,
  // flash pins
  output logic       [ADDR_W-1:0]     flash_addr,
  input  wire  logic [7:0]            flash_dq_in,
  output logic       [7:0]            flash_dq_out,
  output logic                        flash_dq_oe,
  output fhc_pkg::fhc_ctl_t           flash_ctl,
  input  wire  logic                  flash_ready_busy
);
  import fhc_pkg::*;

  // ===========================================================
  // timing counts
  localparam int WE_CYC   = (`FHC_T_WE_NS + `FHC_T_CYC_NS - 1) / `FHC_T_CYC_NS;
  localparam int RD_CYC   = (`FHC_T_RD_NS + `FHC_T_CYC_NS - 1) / `FHC_T_CYC_NS;
  localparam int OUTV_CYC = (`FHC_T_OUTV_NS + `FHC_T_CYC_NS - 1) / `FHC_T_CYC_NS;
  localparam int WAKE_CYC = (`FHC_T_WAKE_NS + `FHC_T_CYC_NS - 1) / `FHC_T_CYC_NS;
  localparam int PD_CYC   = (`FHC_T_PD_NS + `FHC_T_CYC_NS - 1) / `FHC_T_CYC_NS;
  localparam logic [7:0] WE_N   = 8'(WE_CYC);
  localparam logic [7:0] RD_N   = 8'(RD_CYC);
  localparam logic [7:0] WAKE_N = 8'(WAKE_CYC);
  localparam logic [7:0] PD_N   = 8'(PD_CYC);
  localparam logic [7:0] OUTV_N = 8'(OUTV_CYC);

  typedef enum logic [3:0] {
    FHC_ST_IDLE   = 4'h0,
    FHC_ST_WR1    = 4'h1,
    FHC_ST_GAP    = 4'h3,
    FHC_ST_WR2    = 4'h2,
    FHC_ST_POLLW  = 4'h6,
    FHC_ST_POLLR  = 4'h7,
    FHC_ST_RDARR  = 4'h5,
    FHC_ST_RDRET  = 4'h4,
    FHC_ST_PDOWN  = 4'hC,
    FHC_ST_WAKE   = 4'hD
  } fhc_state_t;

  // ===========================================================
  // pin synchronisers
  logic [7:0] dq_s1_r, dq_s2_r;
  logic       rb_s1_r, rb_s2_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
      rb_s1_r <= 1'b1;
      rb_s2_r <= 1'b1;
    end else begin
      dq_s1_r <= flash_dq_in;
      dq_s2_r <= dq_s1_r;
      rb_s1_r <= flash_ready_busy;
      rb_s2_r <= rb_s1_r;
    end
  end

  // ===========================================================
  // software registers
  logic [ADDR_W-1:0] addr_r;
  logic [7:0]        data_r;
  logic [7:0]        rddata_r;
  logic [7:0]        fstat_r;
  logic              err_r, done_r, pd_req_r, susp_r;
  fhc_op_t           op_r;
  logic              start;
  fhc_state_t        st_r;

  // a new operation is taken only while idle; others are dropped
  assign start = reg_wr && (reg_addr == `FHC_ADDR_CTRL) && (st_r == FHC_ST_IDLE);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_r   <= '0;
      data_r   <= 8'h00;
      pd_req_r <= 1'b0;
      op_r     <= FHC_OP_NONE;
    end else begin
      if (reg_wr && reg_addr == `FHC_ADDR_ADDR) begin
        addr_r <= reg_wdata[ADDR_W-1:0];
      end
      if (reg_wr && reg_addr == `FHC_ADDR_DATA) begin
        data_r <= reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == `FHC_ADDR_CTRL) begin
        pd_req_r <= reg_wdata[`FHC_CTRL_PD_BIT];
      end
      if (start) begin
        op_r <= fhc_op_t'(reg_wdata[`FHC_CTRL_OP_LSB +: 4]);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      case (reg_addr)
        `FHC_ADDR_CTRL:   reg_rdata <= {23'h0, pd_req_r, 4'h0, 4'(op_r)};
        `FHC_ADDR_ADDR:   reg_rdata <= 32'(addr_r);
        `FHC_ADDR_DATA:   reg_rdata <= {24'h0, data_r};
        `FHC_ADDR_STATUS: reg_rdata <= {24'h0, 2'b00, rb_s2_r, susp_r, st_r == FHC_ST_IDLE,
                                        pd_req_r, err_r, done_r};
        `FHC_ADDR_RDDATA: reg_rdata <= {24'h0, rddata_r};
        `FHC_ADDR_FSTAT:  reg_rdata <= {24'h0, fstat_r};
        default:          reg_rdata <= 32'h0000_0000;
      endcase
      if (!reg_rd) begin
        reg_rdata <= 32'h0000_0000;
      end
    end
  end

  // ===========================================================
  // sequencer
  logic [7:0] cnt_r;
  logic [7:0] cmd2_r;
  logic       two_r;
  logic       need_poll_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r        <= FHC_ST_PDOWN;
      cnt_r       <= PD_N;
      flash_ctl   <= '{chip_select_b: 1'b1, write_enable_b: 1'b1,
                       output_enable_b: 1'b1, reset_powerdown_b: 1'b0};
      flash_addr  <= '0;
      flash_dq_out <= 8'h00;
      flash_dq_oe <= 1'b0;
      cmd2_r      <= 8'h00;
      two_r       <= 1'b0;
      need_poll_r <= 1'b0;
      rddata_r    <= 8'h00;
      fstat_r     <= 8'h00;
      err_r       <= 1'b0;
      done_r      <= 1'b0;
      susp_r      <= 1'b0;
    end else begin
      if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
      case (st_r)
        FHC_ST_IDLE: begin
          // chip select and reset high leave the flash in standby
          flash_ctl <= '{1'b1, 1'b1, 1'b1, 1'b1};
          flash_dq_oe <= 1'b0;
          if (pd_req_r) begin
            flash_ctl.reset_powerdown_b <= 1'b0;
            susp_r <= 1'b0;
            cnt_r  <= PD_N;
            st_r   <= FHC_ST_PDOWN;
          end else if (start) begin
            done_r <= 1'b0;
            err_r  <= 1'b0;
            flash_addr <= addr_r;
            cnt_r <= WE_N;
            two_r <= 1'b1;
            need_poll_r <= 1'b1;
            st_r  <= FHC_ST_WR1;
            case (fhc_op_t'(reg_wdata[`FHC_CTRL_OP_LSB +: 4]))
              FHC_OP_ERASE: begin
                flash_dq_out <= `FHC_CMD_ERASE_SETUP;
                cmd2_r <= `FHC_CMD_CONFIRM;
              end
              FHC_OP_PROGRAM: begin
                flash_dq_out <= `FHC_CMD_PROGRAM;
                cmd2_r <= data_r;
              end
              FHC_OP_LOCK_BLK: begin
                flash_dq_out <= `FHC_CMD_LOCK_SETUP;
                cmd2_r <= `FHC_CMD_LOCK_BLOCK;
              end
              FHC_OP_LOCK_MSTR: begin
                flash_dq_out <= `FHC_CMD_LOCK_SETUP;
                cmd2_r <= `FHC_CMD_LOCK_MASTER;
              end
              FHC_OP_CLR_LOCKS: begin
                flash_dq_out <= `FHC_CMD_LOCK_SETUP;
                cmd2_r <= `FHC_CMD_CONFIRM;
              end
              FHC_OP_SUSPEND: begin
                flash_dq_out <= `FHC_CMD_SUSPEND;
                two_r <= 1'b0;
                susp_r <= 1'b1;
              end
              FHC_OP_RESUME: begin
                flash_dq_out <= `FHC_CMD_CONFIRM;
                two_r <= 1'b0;
                susp_r <= 1'b0;
              end
              FHC_OP_CLR_STAT: begin
                flash_dq_out <= `FHC_CMD_CLEAR_STATUS;
                two_r <= 1'b0;
                need_poll_r <= 1'b0;
              end
              default: begin
                // plain array read: force read-array mode first
                flash_dq_out <= `FHC_CMD_READ_ARRAY;
                two_r <= 1'b0;
                need_poll_r <= 1'b0;
              end
            endcase
            flash_dq_oe <= 1'b1;
            flash_ctl.chip_select_b  <= 1'b0;
            flash_ctl.write_enable_b <= 1'b0;
          end
        end
        FHC_ST_WR1, FHC_ST_WR2: begin
          if (cnt_r == 8'h01) begin
            // rising write enable; the flash latches address and data here
            flash_ctl.write_enable_b <= 1'b1;
            flash_ctl.chip_select_b  <= 1'b1;
            st_r <= FHC_ST_GAP;
          end
        end
        FHC_ST_GAP: begin
          flash_dq_oe <= 1'b0;
          if (two_r) begin
            two_r <= 1'b0;
            flash_dq_out <= cmd2_r;
            flash_dq_oe <= 1'b1;
            flash_ctl.chip_select_b  <= 1'b0;
            flash_ctl.write_enable_b <= 1'b0;
            cnt_r <= WE_N;
            st_r  <= FHC_ST_WR2;
          end else if (need_poll_r && !susp_r) begin
            cnt_r <= RD_N;
            flash_ctl.chip_select_b   <= 1'b0;
            flash_ctl.output_enable_b <= 1'b0;
            st_r <= FHC_ST_POLLW;
          end else if (op_r == FHC_OP_READ) begin
            cnt_r <= RD_N;
            flash_ctl.chip_select_b   <= 1'b0;
            flash_ctl.output_enable_b <= 1'b0;
            st_r <= FHC_ST_RDARR;
          end else begin
            done_r <= 1'b1;
            st_r <= FHC_ST_IDLE;
          end
        end
        FHC_ST_POLLW: begin
          // busy pin low means the machine still works; poll only once ready
          if (cnt_r == 8'h00 && rb_s2_r) begin
            st_r <= FHC_ST_POLLR;
          end
        end
        FHC_ST_POLLR: begin
          // flash answers status reads after an operation; once ready, error bits set the error flag
          fstat_r <= dq_s2_r;
          if (dq_s2_r[`FHC_FST_READY_BIT]) begin
            err_r  <= |(dq_s2_r & `FHC_FST_ERR_MASK);
            done_r <= 1'b1;
            flash_ctl.output_enable_b <= 1'b1;
            flash_ctl.chip_select_b   <= 1'b1;
            st_r <= FHC_ST_IDLE;
          end
        end
        FHC_ST_RDARR: begin
          if (cnt_r == 8'h00) begin
            st_r <= FHC_ST_RDRET;
          end
        end
        FHC_ST_RDRET: begin
          rddata_r <= dq_s2_r;
          flash_ctl.output_enable_b <= 1'b1;
          flash_ctl.chip_select_b   <= 1'b1;
          done_r <= 1'b1;
          st_r <= FHC_ST_IDLE;
        end
        FHC_ST_PDOWN: begin
          // power-down clears the flash status, so forget local copies
          fstat_r <= 8'h00;
          flash_ctl.reset_powerdown_b <= 1'b0;
          if (cnt_r == 8'h00 && !pd_req_r) begin
            flash_ctl.reset_powerdown_b <= 1'b1;
            // wake time covers output-valid time too
            cnt_r <= (WAKE_N > OUTV_N) ? WAKE_N : OUTV_N;
            st_r  <= FHC_ST_WAKE;
          end
        end
        FHC_ST_WAKE: begin
          // flash leaves power-down in read-array mode; no command needed
          if (cnt_r == 8'h00) begin
            st_r <= FHC_ST_IDLE;
          end
        end
        default: st_r <= FHC_ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** fhc_regs.svh ***
`ifndef FHC_REGS_SVH
`define FHC_REGS_SVH

// controller register offsets (word index on the local port)
`define FHC_ADDR_CTRL     4'h0
`define FHC_ADDR_ADDR     4'h1
`define FHC_ADDR_DATA     4'h2
`define FHC_ADDR_STATUS   4'h3
`define FHC_ADDR_RDDATA   4'h4
`define FHC_ADDR_FSTAT    4'h5

// ctrl register write: bits 3:0 operation code, bit 8 power-down request
`define FHC_CTRL_OP_LSB   0
`define FHC_CTRL_PD_BIT   8

// flash command bytes written to the command interface
`define FHC_CMD_READ_ARRAY   8'hFF
`define FHC_CMD_READ_STATUS  8'h70
`define FHC_CMD_CLEAR_STATUS 8'h50
`define FHC_CMD_ERASE_SETUP  8'h20
`define FHC_CMD_CONFIRM      8'hD0
`define FHC_CMD_PROGRAM      8'h40
`define FHC_CMD_SUSPEND      8'hB0
`define FHC_CMD_LOCK_SETUP   8'h60
`define FHC_CMD_LOCK_BLOCK   8'h01
`define FHC_CMD_LOCK_MASTER  8'hF1

// flash status byte: ready bit and error bits
`define FHC_FST_READY_BIT    7
`define FHC_FST_ERR_MASK     8'h3A

// bus timing in nanoseconds (controller cycle 50 ns)
`define FHC_T_CYC_NS         50
`define FHC_T_WE_NS          100
`define FHC_T_RD_NS          150
`define FHC_T_OUTV_NS        400
`define FHC_T_WAKE_NS        1000
`define FHC_T_PD_NS          100

`endif

// *** fhc_pkg.sv ***
package fhc_pkg;
  typedef enum logic [3:0] {
    FHC_OP_NONE      = 4'h0,
    FHC_OP_READ      = 4'h1,
    FHC_OP_ERASE     = 4'h2,
    FHC_OP_PROGRAM   = 4'h3,
    FHC_OP_SUSPEND   = 4'h4,
    FHC_OP_RESUME    = 4'h5,
    FHC_OP_LOCK_BLK  = 4'h6,
    FHC_OP_LOCK_MSTR = 4'h7,
    FHC_OP_CLR_LOCKS = 4'h8,
    FHC_OP_CLR_STAT  = 4'h9
  } fhc_op_t;

  // pins toward the flash, all driven from flip-flops
  typedef struct packed {
    logic        chip_select_b;
    logic        write_enable_b;
    logic        output_enable_b;
    logic        reset_powerdown_b;
  } fhc_ctl_t;
endpackage

// *** fhc_host_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module fhc_host_asserts import fhc_pkg::*; #(
  parameter int ADDR_W = 21
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              rst_b,
  // register port
  input wire logic [3:0]        reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  // flash pins
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [7:0]        flash_dq_in,
  input wire logic [7:0]        flash_dq_out,
  input wire logic              flash_dq_oe,
  input wire fhc_pkg::fhc_ctl_t flash_ctl,
  input wire logic              flash_ready_busy
);
  // ==========
  // pin and register checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its answer cycle");
  a_wake_quiet: assert property ($rose(flash_ctl.reset_powerdown_b) |->
    flash_ctl.chip_select_b [*8]) else $error("select too soon after wake");
  a_pd_no_write: assert property (!flash_ctl.reset_powerdown_b |->
    flash_ctl.chip_select_b && flash_ctl.write_enable_b) else $error("access in power-down");
  a_we_two: assert property ($fell(flash_ctl.write_enable_b) |=>
    !flash_ctl.write_enable_b ##1 flash_ctl.write_enable_b) else $error("write pulse length");
  a_we_gap: assert property ($fell(flash_ctl.write_enable_b) |->
    $past(flash_ctl.chip_select_b)) else $error("no gap between writes");
  a_we_framed: assert property (!flash_ctl.write_enable_b |-> !flash_ctl.chip_select_b
    && flash_dq_oe && flash_ctl.output_enable_b) else $error("write not framed");
  a_oe_float: assert property (!flash_ctl.output_enable_b |-> !flash_dq_oe)
    else $error("bus fight during read");
  a_data_held: assert property (!flash_ctl.write_enable_b && !$past(flash_ctl.write_enable_b)
    |-> $stable(flash_dq_out) && $stable(flash_addr)) else $error("data moved in write");
endmodule
bind fhc_host fhc_host_asserts #(.ADDR_W(ADDR_W)) u_chk (
  .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_dq_in(flash_dq_in),
  .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_ctl(flash_ctl),
  .flash_ready_busy(flash_ready_busy));
`default_nettype wire

// *** fhc_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fhc_flash_model import fhc_pkg::*; #(
  parameter int BUSY_N = 10
) (
  // busy timing and supply
  input  wire logic              clk,
  input  wire logic              vpp_ok,
  // pins from the controller
  input  wire fhc_pkg::fhc_ctl_t ctl,
  input  wire logic [20:0]       addr,
  input  wire logic [7:0]        dq_wr,
  // pins back to the controller
  output logic [7:0]             dq_rd,
  output logic                   ready_busy
);
  // ==========
  // behavioural array, four blocks, 64 bytes kept per block
  logic [7:0]  mem [256];
  logic [3:0]  lk = 4'h0;
  logic        mlk = 1'b0;
  logic        smode;
  logic        tg = 1'b0;
  logic        wq = 1'b1;
  logic        cq = 1'b1;
  logic        sp = 1'b0;
  logic [7:0]  st;
  logic [7:0]  pend;
  logic [7:0]  d_l;
  logic [20:0] a_l;
  int          bz;
  wire  [1:0]  b = a_l[17:16];
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // released bus toggles every cycle outside power-down so a stale byte never passes
  assign dq_rd = (!ctl.chip_select_b && !ctl.output_enable_b && ctl.reset_powerdown_b) ?
    (smode ? {bz == 0, st[6:0]} : mem[{addr[17:16], addr[5:0]}]) : {4{tg, ~tg}};
  // suspended work holds its count and reports ready
  assign ready_busy = (bz == 0) || sp || !ctl.reset_powerdown_b;
  always @(posedge clk or negedge ctl.reset_powerdown_b) begin
    if (!ctl.reset_powerdown_b) begin
      st <= 8'h80;
      smode <= 1'b0;
      pend <= 8'h00;
      bz <= 0;
      sp <= 1'b0;
    end else begin
      tg <= ~tg;
      wq <= ctl.write_enable_b;
      cq <= ctl.chip_select_b;
      if (!ctl.write_enable_b) begin
        a_l <= addr;
        d_l <= dq_wr;
      end
      if (bz > 0 && !sp) bz <= bz - 1;
      if (ctl.write_enable_b && !wq && !cq) begin
        pend <= 8'h00;
        smode <= 1'b1;
        if (pend == 8'h00) begin
          pend <= (d_l == 8'h20 || d_l == 8'h40 || d_l == 8'h60) ? d_l : 8'h00;
          smode <= (d_l != 8'hFF);
          if (d_l == 8'h50) st <= 8'h80;
          if (d_l == 8'hB0) sp <= 1'b1;
          if (d_l == 8'hD0) sp <= 1'b0;
        end else if (!vpp_ok) st <= 8'h88;
        else if (pend == 8'h20) begin
          if (lk[b] || d_l != 8'hD0) st <= 8'hA2;
          else begin
            for (int i = 0; i < 256; i++) if (i[7:6] == b) mem[i] <= 8'hFF;
            bz <= BUSY_N;
          end
        end else if (pend == 8'h40) begin
          if (lk[b]) st <= 8'h92;
          else begin
            mem[{b, a_l[5:0]}] <= mem[{b, a_l[5:0]}] & d_l;
            bz <= BUSY_N;
          end
        end else if (mlk && d_l != 8'hF1) st <= 8'h82;
        else if (d_l == 8'h01) lk[b] <= 1'b1;
        else if (d_l == 8'hF1) mlk <= 1'b1;
        else if (d_l == 8'hD0) lk <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// *** fhc_host_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module fhc_host_tb;
  import fhc_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        vpp_ok = 1'b1;
  logic [31:0] reg_rdata;
  logic [20:0] f_addr;
  logic [7:0]  dq_in;
  logic [7:0]  dq_out;
  logic        dq_oe;
  logic        rb;
  fhc_ctl_t    ctl;
  logic [31:0] s;
  logic [7:0]  sh [logic [20:0]];
  int          error_cnt = 0;
  int          tests_run = 0;
  always #25 clk = ~clk;
  fhc_host #(.ADDR_W(21)) DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_addr(f_addr), .flash_dq_in(dq_in), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
    .flash_ctl(ctl), .flash_ready_busy(rb));
  fhc_flash_model u_flash (.clk(clk), .vpp_ok(vpp_ok), .ctl(ctl), .addr(f_addr),
    .dq_wr(dq_out), .dq_rd(dq_in), .ready_busy(rb));
  // ==========
  // helpers
  function automatic logic [20:0] fa(input int b, input int o);
    return {3'h0, b[1:0], 10'h0, o[5:0]};
  endfunction
  function automatic logic [7:0] exp_rd(input logic [20:0] a);
    return sh.exists(a) ? sh[a] : 8'hFF;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic idle_wait();
    int n;
    n = 0;
    do begin
      rd(4'h3, s);
      n++;
    end while (s[3] !== 1'b1 && n < 400);
    if (s[3] !== 1'b1) error_cnt++;
  endtask
  // s holds the final status, bit 1 is the error flag
  task automatic op(input logic [3:0] code, input logic [20:0] a, input logic [7:0] d);
    wr(4'h1, {11'h0, a});
    wr(4'h2, {24'h0, d});
    wr(4'h0, {28'h0, code});
    idle_wait();
  endtask
  task automatic print_verdict();
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========
  // tests; the whole run needs well under 20000 cycles
  initial begin
    #3000000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    logic [20:0] a;
    logic [7:0]  d;
    void'($urandom(59168));
    repeat (10) @(posedge clk);
    chk(ctl.reset_powerdown_b, 1'b0);
    rst_b <= 1'b1;
    idle_wait();
    chk(rb, 1'b1);
    for (int i = 0; i < 6; i++) begin
      a = fa($urandom % 2, (i == 0) ? 63 : $urandom);
      d = (i == 0) ? 8'h00 : 8'($urandom);
      op(4'h3, a, d);
      sh[a] = exp_rd(a) & d;
      chk(s[1], 1'b0);
      chk({ctl.chip_select_b, ctl.reset_powerdown_b}, 2'b11);
      op(4'h1, a, 8'h00);
      rd(4'h4, s);
      chk(s[7:0], sh[a]);
    end
    op(4'h2, fa(1, 0), 8'h00);
    foreach (sh[k]) if (k[16]) sh[k] = 8'hFF;
    foreach (sh[k]) begin
      op(4'h1, k, 8'h00);
      rd(4'h4, s);
      chk(s[7:0], sh[k]);
    end
    op(4'h6, fa(1, 0), 8'h00);
    op(4'h3, fa(1, 5), 8'h00);
    chk(s[1], 1'b1);
    rd(4'h5, s);
    chk(|(s[7:0] & 8'h3A), 1'b1);
    op(4'h9, fa(0, 0), 8'h00);
    chk(s[1], 1'b0);
    op(4'h8, fa(0, 0), 8'h00);
    chk(s[1], 1'b0);
    op(4'h3, fa(1, 5), 8'h00);
    sh[fa(1, 5)] = 8'h00;
    chk(s[1], 1'b0);
    op(4'h7, fa(0, 0), 8'h00);
    op(4'h6, fa(0, 0), 8'h00);
    chk(s[1], 1'b1);
    op(4'h9, fa(0, 0), 8'h00);
    vpp_ok <= 1'b0;
    op(4'h3, fa(0, 1), 8'h00);
    chk(s[1], 1'b1);
    vpp_ok <= 1'b1;
    op(4'h9, fa(0, 0), 8'h00);
    // suspend, read another location, then resume
    op(4'h4, fa(0, 0), 8'h00);
    chk(s[4], 1'b1);
    chk(rb, 1'b1);
    op(4'h1, fa(1, 5), 8'h00);
    rd(4'h4, s);
    chk(s[7:0], exp_rd(fa(1, 5)));
    op(4'h5, fa(0, 0), 8'h00);
    chk(s[5:4], 2'b10);
    chk(s[1], 1'b0);
    wr(4'h0, 32'h100);
    repeat (20) if (ctl.reset_powerdown_b !== 1'b0) @(posedge clk);
    chk(ctl.reset_powerdown_b, 1'b0);
    chk(rb, 1'b1);
    wr(4'h0, 32'h0);
    idle_wait();
    op(4'h1, fa(1, 5), 8'h00);
    rd(4'h4, s);
    chk(s[7:0], 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
